// *** dram_symbol_ecc_decoder.sv ***
// symbol oriented ecc decoder for the dram read path with apb status registers
//
// Notes on behaviour
// - 128 data, 16 check bits, 16-bit syndrome
// - four-bit aligned symbols, bit 0 upward
// - any single-bit error corrected; wider errors in one symbol need whole-device mode
// - two-symbol errors flagged, not corrected
// - whole-device repair needs enable and narrow devices
// - lost symbol repaired only when alone
// - x4 ganged device failure is corrected
// - x4 unganged device failure is uncorrectable
// - x8 ganged device failure always detected
// - unganged line built from two beats
// - interleave takes even/odd bits from beats
// - interleaved pin failure stays in one symbol
// - interleaved chip failure over two symbols uncorrectable
// - log failing address and split syndrome
// - only table syndromes are correctable
// - symbols 0-31 data, 32-35 check bits
// - low syndrome nibble is the bit mask
// - data symbol 0 gives e821, 7c32, 9413
// - first check symbol gives be01, d702, 6903
`timescale 1ns/1ps
`default_nettype none
module dram_symbol_ecc_decoder
(
    input wire logic MCLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire ecc_pkg::rd_beat_s IN_BEAT,
    output ecc_pkg::rd_result_s OUT_RESULT
);
    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // syndrome of a whole codeword: xor of the columns of set bits
    function automatic logic [15:0] code_syndrome(input logic [143:0] cw);
        logic [15:0] s;
        s = 16'h0000;
        for (int i = 0; i < ecc_pkg::CODE_BITS; i++)
        begin
            if (cw[i])
                s = s ^ ecc_pkg::BIT_SYNDROME[i];
        end
        return s;
    endfunction

    // syndrome that a given mask in a given symbol produces
    function automatic logic [15:0] symbol_syndrome(input int sym, input logic [3:0] mask);
        logic [15:0] s;
        s = 16'h0000;
        for (int k = 0; k < ecc_pkg::SYMBOL_BITS; k++)
        begin
            if (mask[k])
                s = s ^ ecc_pkg::BIT_SYNDROME[sym * ecc_pkg::SYMBOL_BITS + k];
        end
        return s;
    endfunction

    // even line bits from the first beat, odd from the second
    function automatic logic [143:0] interleave(input logic [71:0] a, input logic [71:0] b);
        logic [143:0] l;
        l = '0;
        for (int i = 0; i < ecc_pkg::BEAT_BITS; i++)
        begin
            l[2 * i] = a[i];
            l[2 * i + 1] = b[i];
        end
        return l;
    endfunction

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic [31:0] nb_error_config_reg;
    logic [31:0] memory_channel_select_reg;
    logic whole_device_correct_enable;
    logic beat_interleave_enable;
    logic unganged;
    logic wide_device;
    logic apb_write;
    logic apb_access;

    assign apb_access = PSEL && PENABLE && PREADY;
    assign apb_write = apb_access && PWRITE;
    assign whole_device_correct_enable = nb_error_config_reg[ecc_pkg::CFG_WHOLE_DEVICE_BIT];
    assign unganged = memory_channel_select_reg[ecc_pkg::SEL_UNGANGED_BIT];
    assign beat_interleave_enable = memory_channel_select_reg[ecc_pkg::SEL_INTERLEAVE_BIT];
    assign wide_device = memory_channel_select_reg[ecc_pkg::SEL_WIDE_DEVICE_BIT];

    // software written mode bits, taken when the access completes
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            nb_error_config_reg <= ecc_pkg::CONFIG_RESET;
            memory_channel_select_reg <= ecc_pkg::CHANNEL_SELECT_RESET;
        end
        else if (apb_write)
        begin
            if (PADDR == ecc_pkg::NB_ERROR_CONFIG_OFS)
                nb_error_config_reg <= {31'h0000_0000, PWDATA[ecc_pkg::CFG_WHOLE_DEVICE_BIT]};
            else if (PADDR == ecc_pkg::MEMORY_CHANNEL_SELECT_OFS)
                memory_channel_select_reg <= {29'h0000_0000, PWDATA[2:0]};
        end
    end

    // ------------------------------------------------------------
    // line assembly
    // ------------------------------------------------------------
    logic first_held;
    logic [71:0] first_beat;
    logic [143:0] line_cw;
    logic [31:0] line_addr;
    logic line_valid;
    logic [71:0] this_beat;

    assign this_beat = {IN_BEAT.check[7:0], IN_BEAT.data[63:0]};

    // first unganged beat waits for its partner
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            first_held <= 1'b0;
            first_beat <= 72'h00_0000_0000_0000_0000;
        end
        else if (IN_BEAT.valid && unganged)
        begin
            first_held <= !IN_BEAT.second;
            if (!IN_BEAT.second)
                first_beat <= this_beat;
        end
    end

    // codeword register: ganged line or two beats from one channel
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            line_valid <= 1'b0;
            line_cw <= '0;
            line_addr <= 32'h0000_0000;
        end
        else
        begin
            line_valid <= 1'b0;
            if (IN_BEAT.valid && !unganged)
            begin
                line_valid <= 1'b1;
                line_cw <= {IN_BEAT.check, IN_BEAT.data};
                line_addr <= IN_BEAT.addr;
            end
            else if (IN_BEAT.valid && IN_BEAT.second && first_held)
            begin
                line_valid <= 1'b1;
                line_addr <= IN_BEAT.addr;
                if (beat_interleave_enable)
                    line_cw <= interleave(first_beat, this_beat);
                else
                    line_cw <= {this_beat[71:64], first_beat[71:64],
                                this_beat[63:0], first_beat[63:0]};
            end
        end
    end

    // ------------------------------------------------------------
    // syndrome decode and correction
    // ------------------------------------------------------------
    logic [15:0] syndrome;
    logic hit;
    logic [5:0] hit_symbol;
    logic multi_bit;
    logic whole_symbol_ok;
    logic next_correctable;
    logic next_uncorrectable;
    logic [143:0] flip;

    assign syndrome = code_syndrome(line_cw);
    assign multi_bit = (syndrome[3:0] & (syndrome[3:0] - 4'h1)) != 4'h0;
    assign whole_symbol_ok = whole_device_correct_enable && !wide_device;

    // search the correctable set: mask is the low nibble
    always_comb
    begin
        hit = 1'b0;
        hit_symbol = 6'h00;
        for (int s = 0; s < ecc_pkg::SYMBOLS; s++)
        begin
            if (!hit && syndrome[3:0] != 4'h0 && symbol_syndrome(s, syndrome[3:0]) == syndrome)
            begin
                hit = 1'b1;
                hit_symbol = 6'(s);
            end
        end
    end

    // single-bit hits always repair; wider masks need whole-device mode
    always_comb
    begin
        next_correctable = hit && (!multi_bit || whole_symbol_ok);
        next_uncorrectable = (syndrome != 16'h0000) && !next_correctable;
        flip = '0;
        if (next_correctable)
            flip[hit_symbol * ecc_pkg::SYMBOL_BITS +: 4] = syndrome[3:0];
    end

    // registered result toward the fabric
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            OUT_RESULT <= '0;
        end
        else
        begin
            OUT_RESULT.valid <= line_valid;
            if (line_valid)
            begin
                OUT_RESULT.correctable <= next_correctable;
                OUT_RESULT.uncorrectable <= next_uncorrectable;
                OUT_RESULT.symbol <= hit_symbol;
                OUT_RESULT.syndrome <= syndrome;
                OUT_RESULT.addr <= line_addr;
                {OUT_RESULT.check, OUT_RESULT.data} <= line_cw ^ flip;
            end
        end
    end

    // ------------------------------------------------------------
    // error log
    // ------------------------------------------------------------
    logic logged;
    logic log_corr;
    logic log_uncorr;
    logic [5:0] log_symbol;
    logic [15:0] log_syndrome;
    logic [31:0] failing_line_address;
    logic take_log;
    logic clear_log;

    assign clear_log = apb_write && PADDR == ecc_pkg::NB_ERROR_STATUS_HIGH_OFS
                       && PWDATA[ecc_pkg::STAT_LOGGED_BIT];
    // an uncorrectable error may replace a logged correctable one
    assign take_log = line_valid && (next_correctable || next_uncorrectable)
                      && (!logged || clear_log || (next_uncorrectable && !log_uncorr));

    // capture wins over a clear in the same cycle
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            logged <= 1'b0;
            log_corr <= 1'b0;
            log_uncorr <= 1'b0;
            log_symbol <= 6'h00;
            log_syndrome <= 16'h0000;
            failing_line_address <= 32'h0000_0000;
        end
        else if (take_log)
        begin
            logged <= 1'b1;
            log_corr <= next_correctable;
            log_uncorr <= next_uncorrectable;
            log_symbol <= hit_symbol;
            log_syndrome <= syndrome;
            failing_line_address <= line_addr;
        end
        else if (clear_log)
        begin
            logged <= 1'b0;
            log_corr <= 1'b0;
            log_uncorr <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // apb slave: one wait state, registered answer
    // ------------------------------------------------------------
    logic [31:0] next_rdata;
    logic next_err;

    // read decode of the mapped words
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        if (PADDR == ecc_pkg::NB_ERROR_CONFIG_OFS)
            next_rdata = nb_error_config_reg;
        else if (PADDR == ecc_pkg::MEMORY_CHANNEL_SELECT_OFS)
            next_rdata = memory_channel_select_reg;
        else if (PADDR == ecc_pkg::NB_ERROR_STATUS_HIGH_OFS)
        begin
            next_rdata[ecc_pkg::STAT_LOGGED_BIT] = logged;
            next_rdata[ecc_pkg::STAT_CORR_BIT] = log_corr;
            next_rdata[ecc_pkg::STAT_UNCORR_BIT] = log_uncorr;
            next_rdata[ecc_pkg::STAT_SYMBOL_LSB +: 6] = log_symbol;
            next_rdata[ecc_pkg::STAT_SYN_LSB +: 8] = log_syndrome[15:8];
        end
        else if (PADDR == ecc_pkg::NB_ERROR_STATUS_LOW_OFS)
            next_rdata[ecc_pkg::STAT_SYN_LSB +: 8] = log_syndrome[7:0];
        else if (PADDR == ecc_pkg::NB_ERROR_ADDRESS_OFS)
            next_rdata = failing_line_address;
        else
            next_err = 1'b1;
    end

    // ready rises in the second access cycle and drops after it
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end
        else
        begin
            PREADY <= PSEL && PENABLE && !PREADY;
            PSLVERR <= PSEL && PENABLE && !PREADY && next_err;
            if (PSEL && PENABLE && !PREADY && !PWRITE)
                PRDATA <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    logic [143:0] rx_q;
    logic whole_ok_q;

    // received codeword and mode kept beside the result
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            rx_q <= '0;
            whole_ok_q <= 1'b0;
        end
        else if (line_valid)
        begin
            rx_q <= line_cw;
            whole_ok_q <= whole_symbol_ok;
        end
    end

    AST_CLEAN_LINE: assert property (@(posedge MCLK) disable iff (RST)
        OUT_RESULT.valid && OUT_RESULT.syndrome == 16'h0000
        |-> !OUT_RESULT.correctable && !OUT_RESULT.uncorrectable
            && {OUT_RESULT.check, OUT_RESULT.data} == rx_q)
        else $error("clean line altered or flagged");
    AST_FLIP_MASK: assert property (@(posedge MCLK) disable iff (RST)
        OUT_RESULT.valid && OUT_RESULT.correctable
        |-> (({OUT_RESULT.check, OUT_RESULT.data} ^ rx_q) >> (OUT_RESULT.symbol * 4))
            == {140'h0, OUT_RESULT.syndrome[3:0]})
        else $error("corrected bits differ from syndrome mask");
    AST_ONE_VERDICT: assert property (@(posedge MCLK) disable iff (RST)
        OUT_RESULT.valid && OUT_RESULT.syndrome != 16'h0000
        |-> OUT_RESULT.correctable != OUT_RESULT.uncorrectable)
        else $error("error line without exactly one verdict");
    AST_DATA0_BIT1: assert property (@(posedge MCLK) disable iff (RST)
        OUT_RESULT.valid && OUT_RESULT.syndrome == 16'h7C32
        |-> OUT_RESULT.correctable && OUT_RESULT.symbol == 6'h00)
        else $error("syndrome 7c32 not decoded to symbol 0");
    AST_CHECK0_PAIR: assert property (@(posedge MCLK) disable iff (RST)
        OUT_RESULT.valid && OUT_RESULT.syndrome == 16'h6903 && whole_ok_q
        |-> OUT_RESULT.correctable && OUT_RESULT.symbol == ecc_pkg::CHECK0_SYMBOL)
        else $error("syndrome 6903 not decoded to first check symbol");
    AST_SYMBOL_RANGE: assert property (@(posedge MCLK) disable iff (RST)
        OUT_RESULT.valid && OUT_RESULT.correctable |-> OUT_RESULT.symbol < 6'd36)
        else $error("corrected symbol out of range");
    AST_WIDE_MASK_GATED: assert property (@(posedge MCLK) disable iff (RST)
        OUT_RESULT.valid && OUT_RESULT.correctable
        && $countones(OUT_RESULT.syndrome[3:0]) > 1 |-> whole_ok_q)
        else $error("multi-bit repair without whole-device mode");
    AST_LOG_CAPTURE: assert property (@(posedge MCLK) disable iff (RST)
        line_valid && next_uncorrectable && !log_uncorr
        |=> logged && log_uncorr && log_syndrome == $past(syndrome))
        else $error("uncorrectable error not logged");
    AST_PAIR_SECOND: assert property (@(posedge MCLK) disable iff (RST)
        unganged && line_valid |-> $past(IN_BEAT.valid && IN_BEAT.second))
        else $error("unganged line without a second beat");
    AST_APB_WAIT: assert property (@(posedge MCLK) disable iff (RST)
        PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
        else $error("apb ready not one cycle after access");
endmodule // dram_symbol_ecc_decoder
`default_nettype wire

// *** dram_symbol_ecc_decoder_tb_top.sv ***
// self-checking testbench for the symbol ecc decoder
`timescale 1ns/1ps
`default_nettype none
module dram_symbol_ecc_decoder_tb_top;
    logic MCLK = 1'h0;
    logic RST = 1'h1;
    logic PSEL = 1'h0;
    logic PENABLE = 1'h0;
    logic PWRITE = 1'h0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY;
    logic PSLVERR;
    ecc_pkg::rd_beat_s IN_BEAT;
    ecc_pkg::rd_result_s OUT_RESULT;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    // 200 MHz clock
    always #2.5 MCLK = ~MCLK;
    dram_symbol_ecc_decoder u_dut (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .IN_BEAT(IN_BEAT), .OUT_RESULT(OUT_RESULT));
    read_path_model u_model (.MCLK(MCLK), .beat(IN_BEAT));
    // --------------------------------------------------------
    // helpers
    // --------------------------------------------------------
    task automatic complete_run();
    begin
        if (err_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask
    task automatic cmp(input logic [143:0] got, input logic [143:0] exp, input string what);
    begin
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
        end
    end
    endtask
    // apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [31:0] exp, input logic experr);
    begin
        @(posedge MCLK);
        PSEL <= 1'h1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'h1;
        @(posedge MCLK);
        while (PREADY !== 1'h1)
            @(posedge MCLK);
        if (!w)
            cmp(PRDATA, exp, "read data");
        cmp(PSLVERR, experr, "slave error");
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
    end
    endtask
    // waits for one result and judges it
    task automatic expect_res(input logic c, input logic u, input logic [5:0] s,
        input logic [15:0] syn);
        int n;
    begin
        n = 0;
        while (OUT_RESULT.valid !== 1'h1 && n < 8)
        begin
            @(posedge MCLK);
            #1;
            n++;
        end
        cmp(OUT_RESULT.valid, 1'h1, "valid");
        cmp(OUT_RESULT.correctable, c, "correctable");
        cmp(OUT_RESULT.uncorrectable, u, "uncorrectable");
        cmp(OUT_RESULT.syndrome, syn, "syndrome");
        cmp(OUT_RESULT.addr, IN_BEAT.addr, "address");
        if (c)
            cmp(OUT_RESULT.symbol, s, "symbol");
        if (!u)
            cmp({OUT_RESULT.check, OUT_RESULT.data}, 144'h0, "data");
    end
    endtask
    // --------------------------------------------------------
    // scenarios
    // --------------------------------------------------------
    // config reset value and the refused address
    task automatic register_cases();
    begin
        apb(1'h0, 12'h044, 32'h0, 32'h0, 1'h0);
        apb(1'h0, 12'h0F0, 32'h0, 32'h0, 1'h1);
    end
    endtask
    // mid-run reset returns mode and log to idle
    task automatic reset_cases();
    begin
        @(posedge MCLK);
        RST <= 1'h1;
        repeat (2) @(posedge MCLK);
        RST <= 1'h0;
        apb(1'h0, 12'h110, 32'h0, 32'h0, 1'h0);
        apb(1'h0, 12'h048, 32'h0, 32'h0, 1'h0);
        apb(1'h0, 12'h050, 32'h0, 32'h0, 1'h0);
    end
    endtask
    task automatic ganged_cases();
    begin
        u_model.send(1'h0, 32'h100, 144'h0);
        expect_res(1'h0, 1'h0, 6'h00, 16'h0000);
        u_model.send(1'h0, 32'h104, 144'h1);
        expect_res(1'h1, 1'h0, 6'h00, 16'hE821);
        u_model.send(1'h0, 32'h108, 144'h2);
        expect_res(1'h1, 1'h0, 6'h00, 16'h7C32);
        apb(1'h0, 12'h050, 32'h0, 32'h104, 1'h0);
        apb(1'h0, 12'h048, 32'h0, 32'hE800_0003, 1'h0);
        apb(1'h0, 12'h04C, 32'h0, 32'h2100_0000, 1'h0);
        apb(1'h1, 12'h048, 32'h1, 32'h0, 1'h0);
        u_model.send(1'h0, 32'h10C, 144'h3);
        expect_res(1'h0, 1'h1, 6'h00, 16'h9413);
        apb(1'h1, 12'h044, 32'h1, 32'h0, 1'h0);
        u_model.send(1'h0, 32'h110, 144'h3);
        expect_res(1'h1, 1'h0, 6'h00, 16'h9413);
        u_model.send(1'h0, 32'h114, 144'h1 << 128);
        expect_res(1'h1, 1'h0, 6'h20, 16'hBE01);
        u_model.send(1'h0, 32'h118, 144'h3 << 128);
        expect_res(1'h1, 1'h0, 6'h20, 16'h6903);
        u_model.send(1'h0, 32'h11C, 144'h11);
        expect_res(1'h0, 1'h1, 6'h00, 16'hB510);
        u_model.send(1'h0, 32'h124, 144'hF0);
        expect_res(1'h1, 1'h0, 6'h01, 16'h846F);
        u_model.send(1'h0, 32'h128, 144'hF1);
        expect_res(1'h0, 1'h1, 6'h00, 16'h6C4E);
        apb(1'h1, 12'h110, 32'h4, 32'h0, 1'h0);
        u_model.send(1'h0, 32'h120, 144'h3);
        expect_res(1'h0, 1'h1, 6'h00, 16'h9413);
        u_model.send(1'h0, 32'h12C, 144'hFF);
        expect_res(1'h0, 1'h1, 6'h00, 16'h76B0);
    end
    endtask
    task automatic unganged_cases();
    begin
        apb(1'h1, 12'h110, 32'h1, 32'h0, 1'h0);
        u_model.send(1'h0, 32'h200, 144'h0);
        u_model.send(1'h1, 32'h200, 144'h1);
        expect_res(1'h1, 1'h0, 6'h10, 16'h45D1);
        u_model.send(1'h0, 32'h204, 144'hF);
        u_model.send(1'h1, 32'h204, 144'hF);
        expect_res(1'h0, 1'h1, 6'h00, 16'hC440);
        apb(1'h1, 12'h110, 32'h3, 32'h0, 1'h0);
        u_model.send(1'h0, 32'h208, 144'h1);
        u_model.send(1'h1, 32'h208, 144'h1);
        expect_res(1'h1, 1'h0, 6'h00, 16'h9413);
        u_model.send(1'h0, 32'h20C, 144'hF);
        u_model.send(1'h1, 32'h20C, 144'hF);
        expect_res(1'h0, 1'h1, 6'h00, 16'h76B0);
    end
    endtask
    // bench watchdog
    always @(posedge MCLK)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            err_count++;
            complete_run();
        end
    end
    // main sequence
    initial
    begin
        repeat (2) @(posedge MCLK);
        RST <= 1'h0;
        register_cases();
        ganged_cases();
        unganged_cases();
        reset_cases();
        complete_run();
    end
endmodule // dram_symbol_ecc_decoder_tb_top
`default_nettype wire

// *** ecc_pkg.sv ***
// shared constants, types and syndrome table for the symbol ecc decoder
`default_nettype none
package ecc_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] NB_ERROR_CONFIG_OFS = 12'h044;
    localparam logic [11:0] NB_ERROR_STATUS_HIGH_OFS = 12'h048;
    localparam logic [11:0] NB_ERROR_STATUS_LOW_OFS = 12'h04C;
    localparam logic [11:0] NB_ERROR_ADDRESS_OFS = 12'h050;
    localparam logic [11:0] MEMORY_CHANNEL_SELECT_OFS = 12'h110;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int CFG_WHOLE_DEVICE_BIT = 0;
    localparam int SEL_UNGANGED_BIT = 0;
    localparam int SEL_INTERLEAVE_BIT = 1;
    localparam int SEL_WIDE_DEVICE_BIT = 2;
    localparam int STAT_LOGGED_BIT = 0;
    localparam int STAT_CORR_BIT = 1;
    localparam int STAT_UNCORR_BIT = 2;
    localparam int STAT_SYMBOL_LSB = 8;
    localparam int STAT_SYN_LSB = 24;
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
    localparam logic [31:0] CHANNEL_SELECT_RESET = 32'h0000_0000;
    // ------------------------------------------------------------
    // code geometry
    // ------------------------------------------------------------
    localparam int SYMBOL_BITS = 4;
    localparam int DATA_BITS = 128;
    localparam int CHECK_BITS = 16;
    localparam int CODE_BITS = 144;
    localparam int SYMBOLS = 36;
    localparam int BEAT_BITS = 72;
    localparam logic [5:0] CHECK0_SYMBOL = 6'h20;
    // syndrome of each single bit, four per symbol, symbol 0 first
    localparam logic [0:143][15:0] BIT_SYNDROME = '{
        16'hE821, 16'h7C32, 16'hBB44, 16'hDD88, 16'h5D31, 16'hA612, 16'h9584, 16'hEAC8,
        16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h2021, 16'h3032, 16'h4044, 16'h8088,
        16'h5041, 16'hA082, 16'h9054, 16'hE0A8, 16'hBE21, 16'hD732, 16'h2144, 16'h3288,
        16'h4951, 16'h8EA2, 16'h5394, 16'hA1E8, 16'h74E1, 16'h9872, 16'hD6B4, 16'h6BD8,
        16'h15C1, 16'h2A42, 16'hCEF4, 16'h4758, 16'h3D01, 16'h1602, 16'h8504, 16'hCA08,
        16'h9801, 16'hEC02, 16'h6B04, 16'hBD08, 16'hD131, 16'h6212, 16'h3884, 16'h1CC8,
        16'hE1D1, 16'h7262, 16'hB834, 16'hDC18, 16'h6051, 16'hB0A2, 16'h1094, 16'h20E8,
        16'hA4C1, 16'hF842, 16'hE6F4, 16'h7B58, 16'h11C1, 16'h2242, 16'hC8F4, 16'h4C58,
        16'h45D1, 16'h8A62, 16'h5E34, 16'hA718, 16'h63E1, 16'hB172, 16'h14B4, 16'h28D8,
        16'hB741, 16'hD982, 16'h2254, 16'h33A8, 16'hDD41, 16'h6682, 16'h3554, 16'h1AA8,
        16'h2BD1, 16'h3D62, 16'h4F34, 16'h8518, 16'h83C1, 16'hC142, 16'hA4F4, 16'hF858,
        16'h8FD1, 16'hC562, 16'hA934, 16'hFE18, 16'h4791, 16'h89E2, 16'h5264, 16'hA3B8,
        16'h5781, 16'hA9C2, 16'h92A4, 16'hE3F8, 16'hBF41, 16'hD582, 16'h2954, 16'h3EA8,
        16'h9391, 16'hE1E2, 16'h6464, 16'hB8B8, 16'hCCE1, 16'h4472, 16'hFDB4, 16'h56D8,
        16'hA761, 16'hF9B2, 16'hE214, 16'h7328, 16'hFF61, 16'h55B2, 16'h7914, 16'h9E28,
        16'h5451, 16'hA8A2, 16'h9694, 16'hEBE8, 16'h6FC1, 16'hB542, 16'h19F4, 16'h2E58,
        16'hBE01, 16'hD702, 16'h2104, 16'h3208, 16'h4101, 16'h8202, 16'h5804, 16'hAC08,
        16'hC441, 16'h4882, 16'hF654, 16'h5BA8, 16'h7621, 16'h9B32, 16'hDA44, 16'h6F88
    };
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic second;
        logic [31:0] addr;
        logic [15:0] check;
        logic [127:0] data;
    } rd_beat_s;
    typedef struct packed {
        logic valid;
        logic correctable;
        logic uncorrectable;
        logic [5:0] symbol;
        logic [15:0] syndrome;
        logic [31:0] addr;
        logic [15:0] check;
        logic [127:0] data;
    } rd_result_s;
endpackage
`default_nettype wire

// *** read_path_model.sv ***
// read path model that hands data beats to the decoder
`timescale 1ns/1ps
`default_nettype none
module read_path_model
(
    input wire logic MCLK,
    output var ecc_pkg::rd_beat_s beat
);
    // bus idles with valid low
    initial beat = '0;
    // one beat per call, raised after an edge, held one cycle
    task automatic send(input logic sec, input logic [31:0] a, input logic [143:0] w);
    begin
        @(posedge MCLK);
        beat <= {1'h1, sec, a, w};
        @(posedge MCLK);
        // released payload shows the inverse of the last value
        beat <= {1'h0, sec, a, ~w};
    end
    endtask
endmodule // read_path_model
`default_nettype wire
